// file: logic/pma_pkg.sv
/*
  Package of the power-profile and fault-summary register bank: register
  indexes, reset values, profile codes, field positions and bus carriers.
  Assumes a 32-bit AXI4-Lite slave where byte address = 4 * register index.
*/
`default_nettype none
package pma_pkg;
  localparam int IDX_W = 12;
  localparam int ADDR_W = IDX_W + 2;
  // printed offsets are not all word aligned, so they are kept as indexes
  localparam logic [IDX_W-1:0] IDX_PROFILE_B = 12'h29a;
  localparam logic [IDX_W-1:0] IDX_PROFILE_C = 12'h29b;
  localparam logic [IDX_W-1:0] IDX_PROFILE_D = 12'h29c;
  localparam logic [IDX_W-1:0] IDX_SUMMARY = 12'h2c0;
  localparam logic [IDX_W-1:0] IDX_FAULT_STATUS = 12'h2c1;
  localparam logic [IDX_W-1:0] IDX_FAULT_MASK = 12'h2c2;
  localparam logic [IDX_W-1:0] IDX_CTRL = 12'h2c8;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h2c9;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h2ca;

  localparam logic [7:0] CODE_LOW_B = 8'h06;
  localparam logic [7:0] CODE_HIGH_B = 8'h0f;
  localparam logic [7:0] CODE_LOW_C = 8'h00;
  localparam logic [7:0] CODE_HIGH_C = 8'h04;
  localparam logic [7:0] CODE_LOW_D = 8'h14;
  localparam logic [7:0] CODE_HIGH_D = 8'h1b;
  localparam logic [7:0] RST_PROFILE_B = CODE_HIGH_B;
  localparam logic [7:0] RST_PROFILE_C = CODE_HIGH_C;
  localparam logic [7:0] RST_PROFILE_D = CODE_HIGH_D;

  localparam int FAULT_W = 6;
  localparam logic [FAULT_W-1:0] RST_FAULT_STATUS = 6'h3f;
  localparam logic [FAULT_W-1:0] RST_FAULT_MASK = 6'h00;

  localparam int CTRL_CAL_EN_BIT = 0;
  localparam int CTRL_LINK_EN_BIT = 1;
  localparam int CTRL_PIN_SEL_BIT = 2;
  localparam logic [2:0] RST_CTRL = 3'h0;

  localparam int IRQ_W = 4;
  localparam int IRQ_SUMMARY_BIT = 0;
  localparam int IRQ_MIXED_BIT = 1;
  localparam int IRQ_RSVD_CODE_BIT = 2;
  localparam int IRQ_WR_ENABLED_BIT = 3;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PM_HIGH = 2'b00,
    PM_LOW = 2'b01,
    PM_RSVD = 2'b10
  } pma_mode_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
    logic strb;
  } pma_wr_req_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
  } pma_rd_req_t;
endpackage
`default_nettype wire

// file: logic/pma_sync.sv
/*
  Three-stage input synchroniser; the output follows only once the second
  and third stages agree. Assumes inputs asynchronous to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module pma_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

  initial begin
    if (W < 1) $error("pma_sync: W must be at least 1");
  end

  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) q_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule // pma_sync
`default_nettype wire

// file: logic/pma_axil_slave.sv
/*
  AXI4-Lite slave front end: takes address and data in either order, hands
  one write or read strobe to the register file, answers from flip-flops.
  Assumes the register file answers rd_data_i/errors in the strobe cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module pma_axil_slave
  import pma_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [ADDR_W-1:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [ADDR_W-1:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic wr_valid_o,
  output pma_wr_req_t wr_req_o,
  input wire logic wr_err_i,
  output logic rd_valid_o,
  output pma_rd_req_t rd_req_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_err_i
);
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  pma_wr_req_t wreq_r, wreq_nxt;

  // commit only once both halves are held and the last response is gone
  assign wr_valid_o = !awready_r && !wready_r && !bvalid_r;
  assign wr_req_o = wreq_r;
  assign rd_valid_o = arvalid_i && arready_r;
  assign rd_req_o.idx = araddr_i[ADDR_W-1:2];

  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    wreq_nxt = wreq_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (awvalid_i && awready_r) begin
      wreq_nxt.idx = awaddr_i[ADDR_W-1:2];
      awready_nxt = 1'b0;
    end
    if (wvalid_i && wready_r) begin
      wreq_nxt.data = wdata_i[7:0];
      wreq_nxt.strb = wstrb_i[0];
      wready_nxt = 1'b0;
    end
    if (bvalid_r && bready_i) bvalid_nxt = 1'b0;
    if (wr_valid_o) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_err_i ? RESP_SLVERR : RESP_OKAY;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    if (rvalid_r && rready_i) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (rd_valid_o) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rd_data_i};
      rresp_nxt = rd_err_i ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      wreq_r <= '0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      wreq_r <= wreq_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign awready_o = awready_r;
  assign wready_o = wready_r;
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign arready_o = arready_r;
  assign rvalid_o = rvalid_r;
  assign rresp_o = rresp_r;
  assign rdata_o = rdata_r;
endmodule // pma_axil_slave
`default_nettype wire

// file: logic/pma_regs.sv
/*
  Power-profile and fault-summary register bank with interrupt logic.
  Assumes fault conditions and calibration status arrive asynchronously
  on pins; software reaches the bank over AXI4-Lite on CLK_I.
*/
// Contract
// R1 - profile b: 0x06 low, 0x0F high
// R2 - profile c: 0x00 low, 0x04 high
// R3 - profile d: 0x14 low, 0x1B high
// R4 - software writes only listed profile codes
// R5 - software programs all profiles to one profile
// R6 - low profile only at or below 1 GSPS
// R7 - software calibrates after each profile change
// R8 - cal and link disabled before profile writes
// R9 - summary bit 0 is any unmasked fault
// R10 - masked faults are excluded from summary
// R11 - pin select routes summary to status pin
// R12 - writing one clears fault; recurrence sets it
// R13 - all fault flags set after reset
// R14 - summary follows status and mask each cycle
`timescale 1ns/10ps
`default_nettype none
module pma_regs
  import pma_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  input wire logic [FAULT_W-1:0] FAULT_COND_I,
  input wire logic CAL_STATUS_I,
  output logic [5:0] PROFILE_MODE_O,
  output logic LOW_POWER_O,
  output logic CAL_ENABLE_O,
  output logic SERIAL_LINK_ENABLE_O,
  output logic STATUS_OUTPUT_PIN_O,
  output logic IRQ_O
);
  function automatic pma_mode_t decode_mode(input logic [7:0] code,
      input logic [7:0] lo, input logic [7:0] hi);
    if (code == lo) return PM_LOW;
    else if (code == hi) return PM_HIGH;
    else return PM_RSVD;
  endfunction

  logic wr_valid, rd_valid, wr_err, rd_err, wr_hit;
  pma_wr_req_t wr_req;
  pma_rd_req_t rd_req;
  logic [7:0] rd_data;
  logic [FAULT_W:0] sync_q;
  logic [FAULT_W-1:0] fault_cond;
  logic cal_status;

  logic [7:0] profile_b_r, profile_b_nxt, profile_c_r, profile_c_nxt;
  logic [7:0] profile_d_r, profile_d_nxt;
  logic [FAULT_W-1:0] fault_status_r, fault_status_nxt;
  logic [FAULT_W-1:0] fault_mask_r, fault_mask_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic summary_r, mixed_r, seen_r;
  logic [5:0] mode_r, mode_nxt;
  logic low_r, low_nxt, pin_r, pin_nxt, irq_r, irq_nxt;
  logic summary_live, mixed_live, profile_wr, rsvd_wr;
  pma_mode_t mode_b, mode_c, mode_d, wr_mode;

  pma_axil_slave u_axil (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .awvalid_i(S_AXI_AWVALID_I),
    .awready_o(S_AXI_AWREADY_O),
    .awaddr_i(S_AXI_AWADDR_I),
    .wvalid_i(S_AXI_WVALID_I),
    .wready_o(S_AXI_WREADY_O),
    .wdata_i(S_AXI_WDATA_I),
    .wstrb_i(S_AXI_WSTRB_I),
    .bvalid_o(S_AXI_BVALID_O),
    .bready_i(S_AXI_BREADY_I),
    .bresp_o(S_AXI_BRESP_O),
    .arvalid_i(S_AXI_ARVALID_I),
    .arready_o(S_AXI_ARREADY_O),
    .araddr_i(S_AXI_ARADDR_I),
    .rvalid_o(S_AXI_RVALID_O),
    .rready_i(S_AXI_RREADY_I),
    .rdata_o(S_AXI_RDATA_O),
    .rresp_o(S_AXI_RRESP_O),
    .wr_valid_o(wr_valid),
    .wr_req_o(wr_req),
    .wr_err_i(wr_err),
    .rd_valid_o(rd_valid),
    .rd_req_o(rd_req),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  pma_sync #(.W(FAULT_W + 1)) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .d_i({CAL_STATUS_I, FAULT_COND_I}),
    .q_o(sync_q)
  );
  assign fault_cond = sync_q[FAULT_W-1:0];
  assign cal_status = sync_q[FAULT_W];

  // summary is combinational so a clear or mask shows on the next read
  assign summary_live = |(fault_status_r & ~fault_mask_r); // R9 R10 R14
  assign mode_b = decode_mode(profile_b_r, CODE_LOW_B, CODE_HIGH_B); // R1
  assign mode_c = decode_mode(profile_c_r, CODE_LOW_C, CODE_HIGH_C); // R2
  assign mode_d = decode_mode(profile_d_r, CODE_LOW_D, CODE_HIGH_D); // R3
  // a mix of profiles is not prevented, only reported to software
  assign mixed_live = (mode_b != mode_c) || (mode_c != mode_d); // R5
  assign wr_hit = wr_valid && wr_req.strb;
  assign profile_wr = wr_hit && (wr_req.idx == IDX_PROFILE_B ||
      wr_req.idx == IDX_PROFILE_C || wr_req.idx == IDX_PROFILE_D);

  always_comb begin
    case (wr_req.idx)
      IDX_PROFILE_B: wr_mode = decode_mode(wr_req.data, CODE_LOW_B,
          CODE_HIGH_B);
      IDX_PROFILE_C: wr_mode = decode_mode(wr_req.data, CODE_LOW_C,
          CODE_HIGH_C);
      default: wr_mode = decode_mode(wr_req.data, CODE_LOW_D, CODE_HIGH_D);
    endcase
  end
  assign rsvd_wr = profile_wr && (wr_mode == PM_RSVD); // R4

  always_comb begin
    wr_err = 1'b0;
    case (wr_req.idx)
      IDX_PROFILE_B, IDX_PROFILE_C, IDX_PROFILE_D, IDX_SUMMARY,
      IDX_FAULT_STATUS, IDX_FAULT_MASK, IDX_CTRL, IDX_IRQ_STATUS,
      IDX_IRQ_MASK: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_comb begin
    rd_data = 8'h00;
    rd_err = 1'b0;
    case (rd_req.idx)
      IDX_PROFILE_B: rd_data = profile_b_r;
      IDX_PROFILE_C: rd_data = profile_c_r;
      IDX_PROFILE_D: rd_data = profile_d_r;
      IDX_SUMMARY: rd_data = {7'h00, summary_live}; // R9
      IDX_FAULT_STATUS: rd_data = {2'h0, fault_status_r};
      IDX_FAULT_MASK: rd_data = {2'h0, fault_mask_r};
      IDX_CTRL: rd_data = {5'h00, ctrl_r};
      IDX_IRQ_STATUS: rd_data = {4'h0, irq_stat_r};
      IDX_IRQ_MASK: rd_data = {4'h0, irq_mask_r};
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    profile_b_nxt = profile_b_r;
    profile_c_nxt = profile_c_r;
    profile_d_nxt = profile_d_r;
    fault_status_nxt = fault_status_r;
    fault_mask_nxt = fault_mask_r;
    ctrl_nxt = ctrl_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    if (wr_hit) begin
      case (wr_req.idx)
        IDX_PROFILE_B: profile_b_nxt = wr_req.data;
        IDX_PROFILE_C: profile_c_nxt = wr_req.data;
        IDX_PROFILE_D: profile_d_nxt = wr_req.data;
        IDX_FAULT_STATUS: fault_status_nxt = fault_status_r &
            ~wr_req.data[FAULT_W-1:0]; // R12
        IDX_FAULT_MASK: fault_mask_nxt = wr_req.data[FAULT_W-1:0];
        IDX_CTRL: ctrl_nxt = wr_req.data[2:0];
        IDX_IRQ_MASK: irq_mask_nxt = wr_req.data[IRQ_W-1:0];
        default: ;
      endcase
    end
    // a recurring condition wins over a clear in the same cycle
    fault_status_nxt = fault_status_nxt | fault_cond; // R12
    if (rd_valid && rd_req.idx == IDX_IRQ_STATUS) irq_stat_nxt = RST_IRQ;
    irq_stat_nxt[IRQ_SUMMARY_BIT] = irq_stat_nxt[IRQ_SUMMARY_BIT] |
        (summary_live & ~summary_r);
    irq_stat_nxt[IRQ_MIXED_BIT] = irq_stat_nxt[IRQ_MIXED_BIT] |
        (mixed_live & ~mixed_r); // R5
    irq_stat_nxt[IRQ_RSVD_CODE_BIT] = irq_stat_nxt[IRQ_RSVD_CODE_BIT] |
        rsvd_wr; // R4
    irq_stat_nxt[IRQ_WR_ENABLED_BIT] = irq_stat_nxt[IRQ_WR_ENABLED_BIT] |
        (profile_wr && (ctrl_r[CTRL_CAL_EN_BIT] ||
        ctrl_r[CTRL_LINK_EN_BIT])); // R8
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    mode_nxt = {mode_d, mode_c, mode_b}; // R1 R2 R3
    low_nxt = (mode_b == PM_LOW) && !mixed_live;
    pin_nxt = ctrl_r[CTRL_PIN_SEL_BIT] ? summary_live : cal_status; // R11
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      profile_b_r <= RST_PROFILE_B;
      profile_c_r <= RST_PROFILE_C;
      profile_d_r <= RST_PROFILE_D;
      fault_status_r <= RST_FAULT_STATUS; // R13
      fault_mask_r <= RST_FAULT_MASK;
      ctrl_r <= RST_CTRL;
      irq_stat_r <= RST_IRQ;
      irq_mask_r <= RST_IRQ;
      summary_r <= 1'b0;
      mixed_r <= 1'b0;
      seen_r <= 1'b0;
      mode_r <= {PM_HIGH, PM_HIGH, PM_HIGH};
      low_r <= 1'b0;
      pin_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      profile_b_r <= profile_b_nxt;
      profile_c_r <= profile_c_nxt;
      profile_d_r <= profile_d_nxt;
      fault_status_r <= fault_status_nxt;
      fault_mask_r <= fault_mask_nxt;
      ctrl_r <= ctrl_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      summary_r <= summary_live;
      mixed_r <= mixed_live;
      seen_r <= 1'b1;
      mode_r <= mode_nxt;
      low_r <= low_nxt;
      pin_r <= pin_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign PROFILE_MODE_O = mode_r;
  assign LOW_POWER_O = low_r;
  assign CAL_ENABLE_O = ctrl_r[CTRL_CAL_EN_BIT];
  assign SERIAL_LINK_ENABLE_O = ctrl_r[CTRL_LINK_EN_BIT];
  assign STATUS_OUTPUT_PIN_O = pin_r;
  assign IRQ_O = irq_r;

  property p_prof_b;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (profile_b_r == CODE_LOW_B) |=> (PROFILE_MODE_O[1:0] == PM_LOW);
  endproperty
  a_prof_b: assert property (p_prof_b) else $error("profile b decode"); // R1

  property p_prof_c;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (profile_c_r == CODE_HIGH_C) |=> (PROFILE_MODE_O[3:2] == PM_HIGH);
  endproperty
  a_prof_c: assert property (p_prof_c) else $error("profile c decode"); // R2

  property p_prof_d;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (profile_d_r == CODE_LOW_D) ##1 (profile_d_r == CODE_LOW_D)
    |=> (PROFILE_MODE_O[5:4] == PM_LOW);
  endproperty
  a_prof_d: assert property (p_prof_d) else $error("profile d decode"); // R3

  property p_summary_read;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (rd_valid && rd_req.idx == IDX_SUMMARY) |=>
    (S_AXI_RDATA_O ==
     {31'h00000000, |$past(fault_status_r & ~fault_mask_r)});
  endproperty
  a_summary_read: assert property (p_summary_read) // R9
    else $error("summary read wrong");

  property p_mask_all;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (fault_mask_r == 6'h3f) [*2] |-> !summary_r;
  endproperty
  a_mask_all: assert property (p_mask_all) // R10
    else $error("masked fault in summary");

  property p_pin_route;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (ctrl_r[CTRL_PIN_SEL_BIT] && fault_status_r[0] && !fault_mask_r[0])
    |=> STATUS_OUTPUT_PIN_O;
  endproperty
  a_pin_route: assert property (p_pin_route) // R11
    else $error("status pin not routed");

  property p_clear_set;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (wr_hit && wr_req.idx == IDX_FAULT_STATUS &&
     (&wr_req.data[FAULT_W-1:0]))
    |=> (fault_status_r == $past(fault_cond));
  endproperty
  a_clear_set: assert property (p_clear_set) // R12
    else $error("fault clear or set wrong");

  property p_reset_flags;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    !seen_r |-> (fault_status_r == RST_FAULT_STATUS) ##1 IRQ_O == 1'b0;
  endproperty
  a_reset_flags: assert property (p_reset_flags) // R13
    else $error("fault flags not set after reset");

  property p_summary_follow;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    ((fault_status_r & ~fault_mask_r) == 6'h00) |=> !summary_r;
  endproperty
  a_summary_follow: assert property (p_summary_follow) // R14
    else $error("summary lags status");
endmodule // pma_regs
`default_nettype wire

// file: sim/power_mode_alarm_regs_test.sv
/*
  Self-checking bench of the power-profile and fault-summary register bank.
  Assumes pma_pkg and pma_regs; drives AXI4-Lite, fault and cal pins itself.
*/
`timescale 1ns/10ps
`default_nettype none
module power_mode_alarm_regs_test
  import pma_pkg::*;
;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, cal_status;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [FAULT_W-1:0] fault_cond, fb;
  logic [2:0] lo;
  wire awready, wready, bvalid, arready, rvalid, low_power;
  wire cal_en, link_en, stat_pin, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] mode;
  int fail_count, n_checks;
  // read notes: {check, resp, data}; write notes: resp only
  logic [34:0] rd_q[$];
  logic [1:0] wr_q[$];

  pma_regs i_dut (.CLK_I(clk), .RESET_N_I(rst_n),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(bresp),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .FAULT_COND_I(fault_cond), .CAL_STATUS_I(cal_status),
    .PROFILE_MODE_O(mode), .LOW_POWER_O(low_power), .CAL_ENABLE_O(cal_en),
    .SERIAL_LINK_ENABLE_O(link_en), .STATUS_OUTPUT_PIN_O(stat_pin),
    .IRQ_O(irq));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ready is registered, so its level at the falling edge is what the
  // next rising edge samples; this keeps the handshake race free
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic aw, w, b, ta, tw, tb;
    int n;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    n = 0;
    wr_q.push_back(er);
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    while (b) begin
      @(negedge clk);
      ta = aw && awready;
      tw = w && wready;
      tb = bvalid && bready;
      @(posedge clk);
      if (ta) begin awvalid <= 1'b0; aw = 1'b0; end
      if (tw) begin wvalid <= 1'b0; w = 1'b0; end
      if (tb) begin bready <= 1'b0; b = 1'b0; end
      n++;
      if (n > 100) begin fail_count++; stop_test(); end
    end
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY, input logic chk = 1);
    logic ar, r, ta, tr;
    int n;
    ar = 1'b1;
    r = 1'b1;
    n = 0;
    rd_q.push_back({chk, er, 24'h0, d});
    @(posedge clk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= {idx, 2'b00};
    while (r) begin
      @(negedge clk);
      ta = ar && arready;
      tr = rvalid && rready;
      @(posedge clk);
      if (ta) begin arvalid <= 1'b0; ar = 1'b0; end
      if (tr) begin rready <= 1'b0; r = 1'b0; end
      n++;
      if (n > 100) begin fail_count++; stop_test(); end
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // takes the oldest note whenever a response handshake is under way
  always @(negedge clk) begin : monitor
    logic [34:0] e;
    if (rvalid && rready && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      if (e[34]) begin
        check("rdata", rdata, e[31:0]);
        check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
      end
    end
    if (bvalid && bready && wr_q.size() > 0)
      check("bresp", {30'h0, bresp}, {30'h0, wr_q.pop_front()});
  end

  initial begin
    #(20 * 20000);
    fail_count++;
    stop_test();
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, cal_status} = '0;
    {awaddr, araddr, wdata, wstrb, fault_cond} = '0;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(32'hae45));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(IDX_PROFILE_B, 8'h0f);
    rd(IDX_PROFILE_C, 8'h04);
    rd(IDX_PROFILE_D, 8'h1b);
    rd(IDX_FAULT_STATUS, 8'h3f);
    rd(IDX_SUMMARY, 8'h01);
    rd(12'h100, 8'h00, RESP_SLVERR);
    wr(12'h100, 8'h11, RESP_SLVERR);
    cyc(0);
    check("mode", 32'(mode), 32'h0);
    // all-low first, all-high last so later events stay clean
    for (int i = 0; i < 8; i++) begin
      lo = (i == 0) ? 3'h7 : (i == 7 ? 3'h0 : 3'($urandom_range(7, 0)));
      wr(IDX_PROFILE_B, lo[0] ? 8'h06 : 8'h0f);
      wr(IDX_PROFILE_C, lo[1] ? 8'h00 : 8'h04);
      wr(IDX_PROFILE_D, lo[2] ? 8'h14 : 8'h1b);
      rd(IDX_PROFILE_C, lo[1] ? 8'h00 : 8'h04);
      rd(IDX_PROFILE_D, lo[2] ? 8'h14 : 8'h1b);
      cyc(1);
      check("mode", 32'(mode),
          32'({1'b0, lo[2], 1'b0, lo[1], 1'b0, lo[0]}));
      check("low power", 32'(low_power), 32'(lo == 3'h7));
    end
    wr(IDX_PROFILE_B, 8'h55);
    rd(IDX_PROFILE_B, 8'h55);
    cyc(1);
    check("reserved mode", 32'(mode), 32'h2);
    wr(IDX_PROFILE_B, 8'h0f);
    wr(IDX_FAULT_STATUS, 8'h3f);
    rd(IDX_FAULT_STATUS, 8'h00);
    rd(IDX_SUMMARY, 8'h00);
    fb = 6'h01 << $urandom_range(5, 0);
    @(posedge clk);
    fault_cond <= fb;
    cyc(8);
    @(posedge clk);
    fault_cond <= '0;
    rd(IDX_FAULT_STATUS, {2'h0, fb});
    rd(IDX_SUMMARY, 8'h01);
    wr(IDX_FAULT_MASK, {2'h0, ~fb});
    rd(IDX_SUMMARY, 8'h01);
    wr(IDX_FAULT_MASK, {2'h0, fb});
    rd(IDX_SUMMARY, 8'h00);
    wr(IDX_FAULT_MASK, 8'h3f);
    rd(IDX_SUMMARY, 8'h00);
    wr(IDX_FAULT_MASK, 8'h00);
    wr(IDX_SUMMARY, 8'h00);
    rd(IDX_SUMMARY, 8'h01);
    wr(IDX_CTRL, 8'h04);
    cyc(2);
    check("status pin", 32'(stat_pin), 32'h1);
    wr(IDX_FAULT_STATUS, {2'h0, fb});
    cyc(1);
    check("status pin", 32'(stat_pin), 32'h0);
    wr(IDX_CTRL, 8'h03);
    cyc(1);
    check("enables", 32'({cal_en, link_en, stat_pin}), 32'h6);
    @(posedge clk);
    cal_status <= 1'b1;
    cyc(6);
    check("status pin", 32'(stat_pin), 32'h1);
    wr(IDX_CTRL, 8'h00);
    cal_status <= 1'b0;
    // summary rose, profiles mixed and a reserved code was written
    rd(IDX_IRQ_STATUS, 8'h07);
    rd(IDX_IRQ_STATUS, 8'h00);
    @(posedge clk);
    fault_cond <= fb;
    cyc(8);
    @(posedge clk);
    fault_cond <= '0;
    cyc(0);
    check("irq masked", 32'(irq), 32'h0);
    wr(IDX_IRQ_MASK, 8'h01);
    cyc(1);
    check("irq", 32'(irq), 32'h1);
    rd(IDX_IRQ_STATUS, 8'h01);
    cyc(1);
    check("irq cleared", 32'(irq), 32'h0);
    wr(IDX_IRQ_MASK, 8'h00);
    cyc(2);
    stop_test();
  end
endmodule // power_mode_alarm_regs_test
`default_nettype wire
